// file: hdl/tap_detect_map.svh
// Purpose: Register offsets, reset values and timing constants of the tap detector
// Assumes: Included by its bare name; definitions only
// Notes:   Step caps are expressed in units of the 0.625 ms base step
`ifndef TAP_DETECT_MAP_SVH
`define TAP_DETECT_MAP_SVH

// Register offsets
`define TAP_REG_THR_X    8'h23
`define TAP_REG_THR_Y    8'h24
`define TAP_REG_THR_Z    8'h25
`define TAP_REG_WIDTH    8'h26
`define TAP_REG_IGNORE   8'h27

// Reset value shared by all five registers
`define TAP_RESET_VAL    8'h00

// Threshold field occupies bits 6..0
`define TAP_THR_MSB      6

// Sample magnitude to threshold units: 12-bit at +/-8 g, 16 codes per threshold step
`define TAP_MAG_SHIFT    4

// Clock period and base step, both in ns
`define TAP_CLK_PERIOD_NS 20
`define TAP_BASE_STEP_NS  625000

// Largest time-limit step, filter on, in base steps
`define TAP_CAP_F_NORMAL 11'h020
`define TAP_CAP_F_LNLP   11'h080
`define TAP_CAP_F_HIRES  11'h004
`define TAP_CAP_F_LOWPWR 11'h100

// Largest time-limit step, filter off, in base steps
`define TAP_CAP_U_NORMAL 11'h008
`define TAP_CAP_U_LNLP   11'h020
`define TAP_CAP_U_HIRES  11'h001
`define TAP_CAP_U_LOWPWR 11'h040

`endif

// file: hdl/tap_detect_pkg.sv
// Purpose: Types shared by the tap detector and its bench
// Assumes: Constants live in tap_detect_map.svh
// Notes:   Mode codes follow the oversampling field of the power configuration
package tap_detect_pkg;

   // Oversampling mode
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_LNLP   = 2'b01,
      MODE_HIRES  = 2'b10,
      MODE_LOWPWR = 2'b11
   } power_mode_t;

   // Per-axis detector state
   typedef enum logic [1:0] {
      AX_IDLE = 2'b00,
      AX_OVER = 2'b01,
      AX_HOLD = 2'b10
   } axis_state_t;

   // Register access request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       write;
      logic       read;
   } reg_req_t;

   // Acceleration sample, signed, full scale +/-8 g
   typedef struct packed {
      logic signed [11:0] x;
      logic signed [11:0] y;
      logic signed [11:0] z;
   } accel_t;

endpackage

// file: hdl/tap_detect_threshold_timing.sv
// Purpose: Tap threshold compare, pulse width limit and ignore interval timing
// Assumes: Samples, sample tick and configuration come from logic on clk_sys_in
// Notes:   Time-limit and latency steps are built from a 0.625 ms base step
//
// Summary of operation
// RULE1: Three threshold registers, consecutive, bit seven zero
// RULE2: Threshold is seven-bit unsigned in bits six..zero
// RULE3: Codes 1..127, 0.063 g each, fixed 8 g
// RULE4: Crossing the axis threshold starts detection
// RULE5: Valid pulse falls back before time limit
// RULE6: Longest time limit is step times 255
// RULE7: Step depends on mode, filter and rate
// RULE8: Filtered width step table, 1.25 ms upward
// RULE9: Unfiltered width step table, 0.625 ms upward
// RULE10: First pulse starts latency; pulses inside ignored
// RULE11: Software programs latency for single and double
// RULE12: Longest latency is latency step times 255
// RULE13: Filtered latency step table, 2.5 ms upward
// RULE14: Unfiltered latency step table, 1.25 ms upward
// RULE15: All five registers read/write, reset zero
// RULE16: Filter enable comes from outside configuration
// RULE17: Second-tap window starts when latency ends
// RULE18: Events flagged only for enabled axes
// RULE19: Compare once per sample tick
// RULE20: Threshold code zero never detects
`timescale 1ns/1ps
`include "tap_detect_map.svh"

module tap_detect_threshold_timing #(
   // Clock cycles per 0.625 ms base step; shorten for simulation
   parameter int unsigned BASE_CYCLES = `TAP_BASE_STEP_NS / `TAP_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire  logic                       clk_sys_in,
   input  wire  logic                       reset_in,
   // Register access
   input  wire  tap_detect_pkg::reg_req_t   reg_req_in,
   output logic [7:0]                       reg_rdata_out,
   // Samples and sample tick
   input  wire  tap_detect_pkg::accel_t     sample_in,
   input  wire  logic                       sample_tick_in,
   // Outside configuration
   input  wire  logic [2:0]                 sample_rate_in,
   input  wire  tap_detect_pkg::power_mode_t power_mode_in,
   input  wire  logic                       tap_filter_enable_in,
   input  wire  logic [2:0]                 tap_axis_enable_in,
   // Events
   output logic [2:0]                       tap_event_out,
   output logic [2:0]                       tap_negative_out,
   output logic                             ignoring_out,
   output logic                             latency_end_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Base step width, sized to the counter
   localparam logic [15:0] BASE_LAST = 16'(BASE_CYCLES - 1);

   // Complete block state
   typedef struct packed {
      logic [2:0][6:0]                   thr;        // Axis thresholds
      logic [7:0]                        width_lim;  // Time-limit count
      logic [7:0]                        ignore;     // Latency count
      tap_detect_pkg::axis_state_t [2:0] ast;        // Axis detector states
      logic [2:0][7:0]                   wcnt;       // Width steps per axis
      logic [2:0][10:0]                  wsub;       // Base steps within a width step
      logic [15:0]                       base_cnt;   // Base step prescaler
      logic                              ignoring;   // Latency interval running
      logic [7:0]                        lcnt;       // Latency steps
      logic [11:0]                       lsub;       // Base steps within a latency step
      logic [2:0]                        event_q;    // Tap events, one cycle
      logic [2:0]                        neg;        // Polarity at crossing
      logic [2:0]                        neg_q;      // Polarity of last event
      logic                              lat_end;    // Latency end, one cycle
      logic [7:0]                        rdata;      // Read data
   } state_t;

   state_t s;         // Registered state
   state_t next_s;    // Next state

   ////////////////////////////////////////////////////////////////////////////
   // Time-limit step in base steps; the latency step is always twice this
   function automatic logic [10:0] width_step(
      input logic [2:0]                  rate,
      input tap_detect_pkg::power_mode_t mode,
      input logic                        filt
   );
      logic [10:0] raw;     // Sample period in base steps, filter on
      logic [10:0] cap;     // Mode ceiling
      logic [10:0] val;     // Before the ceiling
      raw = 11'h000;
      cap = 11'h000;
      val = 11'h000;
      // Step tracks the sample period until the mode ceiling
      unique case (rate)
         3'h0: raw = 11'h002;
         3'h1: raw = 11'h004;
         3'h2: raw = 11'h008;
         3'h3: raw = 11'h010;
         3'h4: raw = 11'h020;
         3'h5: raw = 11'h080;
         3'h6: raw = 11'h100;
         3'h7: raw = 11'h400;
      endcase
      if (filt) begin
         // Filter on: full sample period [RULE8]
         val = raw;
         unique case (mode)
            tap_detect_pkg::MODE_NORMAL: cap = `TAP_CAP_F_NORMAL;
            tap_detect_pkg::MODE_LNLP:   cap = `TAP_CAP_F_LNLP;
            tap_detect_pkg::MODE_HIRES:  cap = `TAP_CAP_F_HIRES;
            tap_detect_pkg::MODE_LOWPWR: cap = `TAP_CAP_F_LOWPWR;
         endcase
      end else begin
         // Filter off: low power halves, other modes quarter, never under 1 [RULE9]
         val = (mode == tap_detect_pkg::MODE_LOWPWR) ? (raw >> 1) : (raw >> 2);
         if (val == 11'h000) begin
            val = 11'h001;
         end
         unique case (mode)
            tap_detect_pkg::MODE_NORMAL: cap = `TAP_CAP_U_NORMAL;
            tap_detect_pkg::MODE_LNLP:   cap = `TAP_CAP_U_LNLP;
            tap_detect_pkg::MODE_HIRES:  cap = `TAP_CAP_U_HIRES;
            tap_detect_pkg::MODE_LOWPWR: cap = `TAP_CAP_U_LOWPWR;
         endcase
      end
      return (val > cap) ? cap : val;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Combinational helpers seen by the assertions
   logic [10:0]       wstep;     // Width step in base steps
   logic [11:0]       lstep;     // Latency step in base steps
   logic [2:0]        above;     // Axis magnitude above its threshold
   logic [2:0][11:0]  mag;       // Axis magnitude

   // Step selection from rate, mode and outside filter enable [RULE7] [RULE16]
   assign wstep = width_step(sample_rate_in, power_mode_in, tap_filter_enable_in);
   // Latency step is twice the width step in every mode [RULE13] [RULE14]
   assign lstep = {wstep, 1'b0};

   // Magnitudes and threshold compare
   always_comb begin
      logic signed [2:0][11:0] smp;   // Samples by axis
      smp = {sample_in.z, sample_in.y, sample_in.x};
      for (int i = 0; i < 3; i++) begin
         // Absolute value; -2048 maps to 2048 without overflow
         mag[i] = smp[i][11] ? 12'(~smp[i] + 12'h001) : smp[i];
         // Unsigned eight-bit compare with the zero-extended code, code zero disabled [RULE2] [RULE3] [RULE20]
         above[i] = (mag[i][11:`TAP_MAG_SHIFT] > {1'b0, s.thr[i]}) &&
                    (s.thr[i] != 7'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [2:0] hit;        // Valid pulses this cycle
      logic       base_tick;  // Base step boundary
      next_s    = s;
      hit       = 3'b000;
      base_tick = (s.base_cnt == BASE_LAST);
      next_s.event_q = 3'b000;
      next_s.lat_end = 1'b0;

      // Free-running base step prescaler
      next_s.base_cnt = base_tick ? 16'h0000 : 16'(s.base_cnt + 16'h0001);

      // Register writes; threshold bit seven is not stored [RULE1] [RULE15]
      if (reg_req_in.write) begin
         unique case (reg_req_in.addr)
            `TAP_REG_THR_X:  next_s.thr[0]    = reg_req_in.wdata[`TAP_THR_MSB:0];
            `TAP_REG_THR_Y:  next_s.thr[1]    = reg_req_in.wdata[`TAP_THR_MSB:0];
            `TAP_REG_THR_Z:  next_s.thr[2]    = reg_req_in.wdata[`TAP_THR_MSB:0];
            `TAP_REG_WIDTH:  next_s.width_lim = reg_req_in.wdata;
            `TAP_REG_IGNORE: next_s.ignore    = reg_req_in.wdata;
            default: ;       // Unmapped writes are dropped
         endcase
      end

      // Register reads; unmapped offsets answer zero [RULE15]
      if (reg_req_in.read) begin
         unique case (reg_req_in.addr)
            `TAP_REG_THR_X:  next_s.rdata = {1'b0, s.thr[0]};  // [RULE1]
            `TAP_REG_THR_Y:  next_s.rdata = {1'b0, s.thr[1]};
            `TAP_REG_THR_Z:  next_s.rdata = {1'b0, s.thr[2]};
            `TAP_REG_WIDTH:  next_s.rdata = s.width_lim;
            `TAP_REG_IGNORE: next_s.rdata = s.ignore;
            default:         next_s.rdata = 8'h00;
         endcase
      end

      // Per-axis pulse qualification
      for (int i = 0; i < 3; i++) begin
         unique case (s.ast[i])
            tap_detect_pkg::AX_IDLE: begin
               // Start on a crossing seen at a sample tick [RULE4] [RULE19]
               if (sample_tick_in && above[i]) begin
                  next_s.ast[i]  = tap_detect_pkg::AX_OVER;
                  next_s.wcnt[i] = 8'h00;
                  next_s.wsub[i] = 11'h000;
                  next_s.neg[i]  = mag[i] != 12'h000 && (i == 0 ? sample_in.x[11] :
                                   i == 1 ? sample_in.y[11] : sample_in.z[11]);
               end
            end
            tap_detect_pkg::AX_OVER: begin
               // Width measured in steps; 8-bit count caps at step x 255 [RULE6]
               if (base_tick) begin
                  if (11'(s.wsub[i] + 11'h001) >= wstep) begin
                     next_s.wsub[i] = 11'h000;
                     if (s.wcnt[i] != 8'hff) begin
                        next_s.wcnt[i] = 8'(s.wcnt[i] + 8'h01);
                     end
                  end else begin
                     next_s.wsub[i] = 11'(s.wsub[i] + 11'h001);
                  end
               end
               if (s.wcnt[i] >= s.width_lim) begin
                  // Too long: wait for the fall without qualifying [RULE5]
                  next_s.ast[i] = tap_detect_pkg::AX_HOLD;
               end else if (sample_tick_in && !above[i]) begin
                  // Fell back in time: valid pulse [RULE5]
                  next_s.ast[i] = tap_detect_pkg::AX_IDLE;
                  hit[i]        = 1'b1;
               end
            end
            tap_detect_pkg::AX_HOLD: begin
               // Re-arm only after the axis is no longer above its threshold
               if (sample_tick_in && !above[i]) begin
                  next_s.ast[i] = tap_detect_pkg::AX_IDLE;
               end
            end
            default: next_s.ast[i] = tap_detect_pkg::AX_IDLE;
         endcase
      end

      // Latency interval; pulses inside it produce no event [RULE10]
      if (s.ignoring) begin
         if (s.lcnt >= s.ignore) begin
            // Interval over: second-tap window may open now [RULE17] [RULE12]
            next_s.ignoring = 1'b0;
            next_s.lat_end  = 1'b1;
         end else if (base_tick) begin
            if (12'(s.lsub + 12'h001) >= lstep) begin
               next_s.lsub = 12'h000;
               next_s.lcnt = 8'(s.lcnt + 8'h01);
            end else begin
               next_s.lsub = 12'(s.lsub + 12'h001);
            end
         end
      end else if (hit != 3'b000) begin
         // First pulse starts the interval; software sets its length [RULE10] [RULE11]
         next_s.ignoring = 1'b1;
         next_s.lcnt     = 8'h00;
         next_s.lsub     = 12'h000;
         // Only enabled axes raise an event [RULE18]
         next_s.event_q  = hit & tap_axis_enable_in;
         for (int i = 0; i < 3; i++) begin
            if (hit[i]) begin
               next_s.neg_q[i] = s.neg[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; every register resets to zero [RULE15]
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_out    = s.rdata;
   assign tap_event_out    = s.event_q;
   assign tap_negative_out = s.neg_q;
   assign ignoring_out     = s.ignoring;
   assign latency_end_out  = s.lat_end;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   // Latency start followed by its end
   sequence lat_start_s;
      $rose(ignoring_out) && (s.ignore == 8'h00);
   endsequence
   sequence lat_end_s;
      !ignoring_out && latency_end_out;
   endsequence

   a_thr_top_zero: assert property (       // [RULE1]
      reg_req_in.read && (reg_req_in.addr == `TAP_REG_THR_Z) |=> reg_rdata_out[7] == 1'b0)
      else $error("threshold top bit read as one");

   a_unmapped_zero: assert property (      // [RULE15]
      reg_req_in.read && (reg_req_in.addr > `TAP_REG_IGNORE) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");

   a_width_write: assert property (        // [RULE15]
      reg_req_in.write && (reg_req_in.addr == `TAP_REG_WIDTH) |=>
      s.width_lim == $past(reg_req_in.wdata))
      else $error("time limit write not stored");

   a_start_on_cross: assert property (     // [RULE4]
      ($past(s.ast[0]) == tap_detect_pkg::AX_IDLE) && (s.ast[0] == tap_detect_pkg::AX_OVER)
      |-> $past(sample_tick_in && above[0]))
      else $error("detection started without crossing");

   a_zero_thr_idle: assert property (      // [RULE20]
      (s.thr[1] == 7'h00) && (s.ast[1] == tap_detect_pkg::AX_IDLE) && !reg_req_in.write
      |=> s.ast[1] == tap_detect_pkg::AX_IDLE)
      else $error("zero threshold started detection");

   a_event_in_limit: assert property (     // [RULE5]
      tap_event_out[0] |-> $past(s.wcnt[0] < s.width_lim))
      else $error("event after time limit");

   a_no_event_latency: assert property (   // [RULE10]
      $past(ignoring_out) |-> tap_event_out == 3'b000)
      else $error("event inside latency");

   a_event_starts_lat: assert property (   // [RULE10]
      (tap_event_out != 3'b000) |-> ignoring_out)
      else $error("event without latency");

   a_latency_ends: assert property (       // [RULE17]
      lat_start_s |=> lat_end_s)
      else $error("zero latency did not end next cycle");

   a_step_fast_filt: assert property (     // [RULE8]
      (sample_rate_in == 3'h0) && tap_filter_enable_in |-> wstep == 11'h002)
      else $error("filtered fastest step wrong");

   a_step_hires_raw: assert property (     // [RULE9]
      (power_mode_in == tap_detect_pkg::MODE_HIRES) && !tap_filter_enable_in
      |-> wstep == 11'h001)
      else $error("unfiltered high resolution step wrong");

endmodule

// file: verif/tap_host_model.sv
// Purpose: Host side model that reaches the tap registers one byte at a time
// Assumes: Caller enters each task just after a rising edge of clk_sys_in
// Notes:   Released address and data lines show the inverse of their last value; strobes drop to zero
`timescale 1ns/1ps

module tap_host_model (
   // Clock
   input  wire  logic                 clk_sys_in,
   // Register access toward the device
   output tap_detect_pkg::reg_req_t  reg_req_out,
   input  wire  logic [7:0]           reg_rdata_in
);

   ////////////////////////////////////////////////////////////////////////////////
   // Idle request at time zero
   initial begin
      reg_req_out = '0;
   end

   // Drop strobes and scramble address and data, so a stale value never looks valid
   task automatic release_bus();
      reg_req_out.addr  = ~reg_req_out.addr;
      reg_req_out.wdata = ~reg_req_out.wdata;
      reg_req_out.write = 1'b0;
      reg_req_out.read  = 1'b0;
   endtask

   // One write, taken at the next rising edge; an idle cycle follows, so the
   // strobe of a following access is never raised in the time step it fell
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      reg_req_out = '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
      @(posedge clk_sys_in);
      #1;
      release_bus();
      @(posedge clk_sys_in);
      #1;
   endtask

   // One read; the answer is registered on the taking edge and stands after it
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      reg_req_out = '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
      @(posedge clk_sys_in);
      #1;
      d = reg_rdata_in;
      release_bus();
      @(posedge clk_sys_in);
      #1;
   endtask

endmodule

// file: verif/tap_detect_threshold_timing_bench.sv
// Purpose: Self-checking bench of the tap threshold and timing block
// Assumes: BASE_CYCLES of 4, so one 0.625 ms base step is 4 clocks
// Notes:   Step checks allow one short first base step plus pipeline slack
`timescale 1ns/1ps
`include "tap_detect_map.svh"
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module tap_detect_threshold_timing_bench;
   localparam int unsigned BASE = 4;   // Short base step keeps the run brief
   logic                        clk_sys_in = 1'b0;
   logic                        reset_in   = 1'b1;
   tap_detect_pkg::reg_req_t    reg_req;
   logic [7:0]                  reg_rdata;
   tap_detect_pkg::accel_t      sample_in  = '0;
   logic                        sample_tick_in = 1'b0;
   logic [2:0]                  sample_rate_in = 3'h0;
   tap_detect_pkg::power_mode_t power_mode_in  = tap_detect_pkg::MODE_NORMAL;
   logic                        tap_filter_enable_in = 1'b1;
   logic [2:0]                  tap_axis_enable_in   = 3'h7;
   logic [2:0]                  tap_event_out;
   logic [2:0]                  tap_negative_out;
   logic                        ignoring_out;
   logic                        latency_end_out;
   int                          fail_count = 0;
   int                          compares   = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   tap_detect_threshold_timing #(.BASE_CYCLES(BASE)) tap_detect_threshold_timing_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(reg_req),
      .reg_rdata_out(reg_rdata), .sample_in(sample_in), .sample_tick_in(sample_tick_in),
      .sample_rate_in(sample_rate_in), .power_mode_in(power_mode_in),
      .tap_filter_enable_in(tap_filter_enable_in), .tap_axis_enable_in(tap_axis_enable_in),
      .tap_event_out(tap_event_out), .tap_negative_out(tap_negative_out),
      .ignoring_out(ignoring_out), .latency_end_out(latency_end_out));

   tap_host_model tap_host_model_inst (
      .clk_sys_in(clk_sys_in), .reg_req_out(reg_req), .reg_rdata_in(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers: every drive lands 1 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic stop_test();
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   function automatic tap_detect_pkg::accel_t mk(input logic signed [11:0] x, y, z);
      mk = '{x: x, y: y, z: z};
   endfunction

   // Same threshold on all axes, then width limit and ignore count
   task automatic cfg(input logic [7:0] thr, lim, ign);
      tap_host_model_inst.write_reg(`TAP_REG_THR_X, thr);
      tap_host_model_inst.write_reg(`TAP_REG_THR_Y, thr);
      tap_host_model_inst.write_reg(`TAP_REG_THR_Z, thr);
      tap_host_model_inst.write_reg(`TAP_REG_WIDTH, lim);
      tap_host_model_inst.write_reg(`TAP_REG_IGNORE, ign);
   endtask

   // One tick over threshold, hold, one tick back at rest, then gather outputs
   task automatic tap(input tap_detect_pkg::accel_t s, input int hold,
                      output logic [2:0] ev, output logic ig);
      sample_in = s;
      sample_tick_in = 1'b1;
      cyc(1);
      if (hold > 0) begin
         sample_tick_in = 1'b0;
         cyc(hold);
         sample_tick_in = 1'b1;
      end
      sample_in = '0;
      cyc(1);
      sample_tick_in = 1'b0;
      ev = '0;
      ig = 1'b0;
      // Events stand one cycle only, so look before each edge passes
      repeat (6) begin
         ev |= tap_event_out;
         ig |= ignoring_out;
         cyc(1);
      end
   endtask

   // Bounded wait for the ignore interval to close; returns cycles waited
   task automatic wait_quiet(output int n);
      n = 0;
      while (latency_end_out !== 1'b1) begin
         cyc(1);
         n++;
         if (n > 3000) begin
            fail_count++;
            stop_test();
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      logic [7:0] d;
      for (int a = 8'h23; a <= 8'h27; a++) begin
         tap_host_model_inst.read_reg(8'(a), d);
         `CHECK("reset value", 8'h00, d)
         tap_host_model_inst.write_reg(8'(a), 8'hff);
         tap_host_model_inst.read_reg(8'(a), d);
         `CHECK("readback", (a < 8'h26) ? 8'h7f : 8'hff, d)
      end
      tap_host_model_inst.write_reg(8'h28, 8'h5a);
      tap_host_model_inst.read_reg(8'h28, d);
      `CHECK("unmapped read", 8'h00, d)
   endtask

   task automatic t_taps();
      logic [2:0] ev;
      logic       ig;
      int         n;
      cfg(8'h02, 8'h03, 8'h00);
      tap(mk(12'sh040, -12'sh040, -12'sh040), 0, ev, ig);
      `CHECK("three axis event", 3'b111, ev)
      `CHECK("polarity", 3'b110, tap_negative_out)
      tap(mk(12'sh020, 12'sh000, 12'sh000), 0, ev, ig);
      `CHECK("equal to threshold", 3'b000, ev)
      // Large samples without a tick must not start detection
      ev = '0;
      ig = 1'b0;
      for (int k = 0; k < 10; k++) begin
         sample_in = mk((k < 4) ? 12'sh7ff : 12'sh000, 12'sh000, 12'sh000);
         ev |= tap_event_out;
         ig |= ignoring_out;
         cyc(1);
      end
      `CHECK("no tick no compare", 4'b0000, {ev, ig})
      tap_axis_enable_in = 3'b110;
      tap(mk(12'sh040, 12'sh000, 12'sh000), 0, ev, ig);
      `CHECK("disabled axis", 4'b0001, {ev, ig})
      tap_axis_enable_in = 3'b111;
      cfg(8'h00, 8'h03, 8'h00);
      tap(mk(12'sh7ff, 12'sh7ff, 12'sh7ff), 0, ev, ig);
      `CHECK("zero threshold", 3'b000, ev)
      cfg(8'h01, 8'h01, 8'h00);
      tap(mk(12'sh000, 12'sh020, 12'sh000), 1, ev, ig);
      `CHECK("short pulse", 3'b010, ev)
      tap_filter_enable_in = 1'b0;
      tap(mk(12'sh000, 12'sh020, 12'sh000), 30, ev, ig);
      `CHECK("overlong pulse", 3'b000, ev)
      cfg(8'h02, 8'h03, 8'h03);
      tap_filter_enable_in = 1'b1;
      tap(mk(12'sh040, 12'sh000, 12'sh000), 0, ev, ig);
      `CHECK("first tap", 3'b001, ev)
      tap(mk(12'sh040, 12'sh000, 12'sh000), 0, ev, ig);
      `CHECK("tap while ignoring", 4'b0001, {ev, ignoring_out})
      wait_quiet(n);
      `CHECK("ignoring at end", 1'b0, ignoring_out)
   endtask

   // Latency length at table corners; clocks = steps * base steps * BASE
   task automatic t_steps();
      int rate [16] = '{0, 3, 7, 7, 7, 7, 7, 7, 7, 7, 7, 1, 2, 4, 5, 6};
      int mode [16] = '{0, 0, 0, 1, 2, 3, 0, 1, 2, 3, 2, 3, 2, 1, 3, 0};
      int filt [16] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0};
      int ign  [16] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 255, 1, 1, 1, 1, 1};
      int base [16] = '{4, 32, 64, 256, 8, 512, 16, 64, 2, 128, 2, 4, 8, 64, 128, 16};
      int n;
      int want;
      for (int i = 0; i < 16; i++) begin
         sample_rate_in = 3'(rate[i]);
         power_mode_in = tap_detect_pkg::power_mode_t'(mode[i]);
         tap_filter_enable_in = filt[i][0];
         cfg(8'h02, 8'hff, 8'(ign[i]));
         sample_in = mk(12'sh040, 12'sh000, 12'sh000);
         sample_tick_in = 1'b1;
         cyc(1);
         sample_in = '0;
         cyc(1);
         sample_tick_in = 1'b0;
         wait_quiet(n);
         want = ign[i] * base[i] * BASE;
         `CHECK("latency length", 1'b1, (n >= want - 5) && (n <= want + 3))
      end
   endtask

   // Full width limit of 255 steps, one base step each; the first step may be short
   task automatic t_long_width();
      logic [2:0] ev;
      logic       ig;
      sample_rate_in = 3'h7;
      power_mode_in = tap_detect_pkg::MODE_HIRES;
      tap_filter_enable_in = 1'b0;
      cfg(8'h02, 8'hff, 8'h00);
      tap(mk(12'sh040, 12'sh000, 12'sh000), 255 * BASE - 12, ev, ig);
      `CHECK("width just inside", 3'b001, ev)
      tap(mk(12'sh040, 12'sh000, 12'sh000), 255 * BASE + 8, ev, ig);
      `CHECK("width just outside", 3'b000, ev)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(3);
      reset_in = 1'b0;
      cyc(1);
      t_regs();
      t_taps();
      t_steps();
      t_long_width();
      stop_test();
   end

endmodule
